// ===== rtl/acg_config_regs.sv
`include "acg_regs.svh"

// Behaviour
// - oversampling code bits 4:2, reset 011b
// - power code bits 1:0, reset 10b
// - gain register at 4h, reset 0000h
// - channel 3 gain code bits 14:12
// - channel 2 gain code bits 10:8
// - channel 1 gain code bits 6:4
// - channel 0 gain code bits 2:0
module acg_config_regs
    import acg_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int GAIN_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // modulator settings
    output logic [2:0] oversampling_ratio_sel,
    output logic [14:0] oversampling_ratio,
    output logic [1:0] power_mode_sel,
    output acg_power_t power_mode,
    // amplifier gain codes
    output acg_gain_code_t amp_gain_ch0,
    output acg_gain_code_t amp_gain_ch1,
    output acg_gain_code_t amp_gain_ch2,
    output acg_gain_code_t amp_gain_ch3,
    // amplifier gain factors
    output logic [GAIN_W-1:0] amp_gain_ch0_factor,
    output logic [GAIN_W-1:0] amp_gain_ch1_factor,
    output logic [GAIN_W-1:0] amp_gain_ch2_factor,
    output logic [GAIN_W-1:0] amp_gain_ch3_factor
);

    localparam int NUM_CH = 4;

    logic [5:0] clock_cfg_reg;
    logic [15:0] gain_low_reg;
    logic [31:0] readdata_next;
    logic req;
    logic accept;
    logic wr_clock;
    logic wr_gain;
    logic [GAIN_W-1:0] gain_factor [NUM_CH];

    function automatic logic [14:0] ratio_decode(input logic [2:0] code);
        if (code == `ACG_RATIO_TOP_CODE) begin
            ratio_decode = `ACG_RATIO_TOP;
        end else begin
            ratio_decode = `ACG_RATIO_BASE << code;
        end
    endfunction

    function automatic acg_power_t power_decode(input logic [1:0] code);
        unique case (code)
            2'h0: power_decode = ACG_POWER_VERY_LOW;
            2'h1: power_decode = ACG_POWER_LOW;
            2'h2, 2'h3: power_decode = ACG_POWER_HIGH_RES;
        endcase
    endfunction

    function automatic acg_gain_code_t gain_field(input logic [15:0] r, input int ch);
        gain_field = r[ch*`ACG_GAIN_STRIDE +: 3];
    endfunction

    // bus handshake: one wait cycle, then the access completes
    assign req = avs_read || avs_write;
    assign accept = req && !avs_waitrequest;
    assign wr_clock = accept && avs_write && (avs_address == ADDR_W'(`ACG_ADDR_CLOCK));
    assign wr_gain = accept && avs_write && (avs_address == ADDR_W'(`ACG_ADDR_GAIN_LOW));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        readdata_next = 32'h0000_0000;
        if (avs_address == ADDR_W'(`ACG_ADDR_CLOCK)) begin
            readdata_next = {26'h000_0000, clock_cfg_reg};
        end else if (avs_address == ADDR_W'(`ACG_ADDR_GAIN_LOW)) begin
            readdata_next = {16'h0000, gain_low_reg};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= readdata_next;
        end
    end

    // clock configuration; reserved bit stored as written
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clock_cfg_reg <= `ACG_CLOCK_RESET;
        end else if (wr_clock && avs_byteenable[0]) begin
            clock_cfg_reg <= avs_writedata[5:0];
        end
    end

    // gain register, byte lanes honoured
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gain_low_reg <= `ACG_GAIN_RESET;
        end else if (wr_gain) begin
            if (avs_byteenable[0]) begin
                gain_low_reg[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                gain_low_reg[15:8] <= avs_writedata[15:8];
            end
        end
    end

    assign oversampling_ratio_sel = clock_cfg_reg[`ACG_RATIO_MSB:`ACG_RATIO_LSB];
    assign power_mode_sel = clock_cfg_reg[`ACG_POWER_MSB:`ACG_POWER_LSB];

    // decoded modulator settings, one cycle behind the codes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            oversampling_ratio <= ratio_decode(3'(`ACG_CLOCK_RESET >> `ACG_RATIO_LSB));
        end else begin
            oversampling_ratio <= ratio_decode(oversampling_ratio_sel);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            power_mode <= ACG_POWER_HIGH_RES;
        end else begin
            power_mode <= power_decode(power_mode_sel);
        end
    end

    assign amp_gain_ch0 = gain_low_reg[2:0];
    assign amp_gain_ch1 = gain_low_reg[6:4];
    assign amp_gain_ch2 = gain_low_reg[10:8];
    assign amp_gain_ch3 = gain_low_reg[14:12];

    // one decoder per channel, each fed only its own field
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_gain
        acg_gain_decode #(
            .GAIN_W(GAIN_W)
        ) u_dec (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .gain_code(gain_field(gain_low_reg, ch)),
            .gain_factor(gain_factor[ch])
        );
    end

    assign amp_gain_ch0_factor = gain_factor[0];
    assign amp_gain_ch1_factor = gain_factor[1];
    assign amp_gain_ch2_factor = gain_factor[2];
    assign amp_gain_ch3_factor = gain_factor[3];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_wait_one_cycle: assert property (
        req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");

    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    a_reset_state: assert property (
        disable iff (1'b0) sys_rst |=> clock_cfg_reg == `ACG_CLOCK_RESET
            && gain_low_reg == `ACG_GAIN_RESET
            && avs_waitrequest && avs_readdata == 32'h0000_0000)
        else $error("registers not at reset values after reset");

    // clock configuration register
    a_clock_write: assert property (
        wr_clock && avs_byteenable[0] |=> clock_cfg_reg == $past(avs_writedata[5:0]))
        else $error("clock configuration not written");

    a_clock_hold: assert property (
        !(wr_clock && avs_byteenable[0]) |=> $stable(clock_cfg_reg))
        else $error("clock configuration changed without a write");

    a_ratio_write: assert property (
        wr_clock && avs_byteenable[0] |=> ##1 oversampling_ratio ==
            ratio_decode($past(avs_writedata[4:2], 2)))
        else $error("oversampling ratio not decoded from written code");

    a_ratio_top: assert property (
        oversampling_ratio_sel == 3'h7 |=> oversampling_ratio == 15'h3f80)
        else $error("top oversampling code wrong");

    a_power_decode: assert property (
        power_mode_sel[1] |=> power_mode == ACG_POWER_HIGH_RES)
        else $error("power codes 10b and 11b must be high resolution");

    a_power_low: assert property (
        power_mode_sel == 2'h1 |=> power_mode == ACG_POWER_LOW)
        else $error("power code 01b must be low power");

    a_power_very_low: assert property (
        power_mode_sel == 2'h0 |=> power_mode == ACG_POWER_VERY_LOW)
        else $error("power code 00b must be very low power");

    a_ratio_min: assert property (
        oversampling_ratio_sel == 3'h0 |=> oversampling_ratio == 15'h0080)
        else $error("lowest oversampling code wrong");

    a_ratio_default: assert property (
        oversampling_ratio_sel == 3'h3 |=> oversampling_ratio == 15'h0400)
        else $error("default oversampling code wrong");

    a_ratio_high: assert property (
        oversampling_ratio_sel == 3'h6 |=> oversampling_ratio == 15'h2000)
        else $error("oversampling code 110b wrong");

    a_gain_write: assert property (
        wr_gain && avs_byteenable[1:0] == 2'h3 |=>
            gain_low_reg == $past(avs_writedata[15:0]))
        else $error("gain register not written at its address");

    // gain field routing
    a_gain_low_lane: assert property (
        wr_gain && avs_byteenable[1:0] == 2'h1 |=> gain_low_reg ==
            {$past(gain_low_reg[15:8]), $past(avs_writedata[7:0])})
        else $error("low byte lane write wrong");

    a_gain_hold: assert property (
        !wr_gain |=> $stable(gain_low_reg))
        else $error("gain register changed without a write");

    a_gain_own_channel: assert property (
        wr_gain && avs_byteenable[1:0] == 2'h1 |=>
            $stable(amp_gain_ch2) && $stable(amp_gain_ch3))
        else $error("low lane write moved a high channel gain");

    a_gain_ch3_code: assert property (
        wr_gain && avs_byteenable[1] |=> amp_gain_ch3 == $past(avs_writedata[14:12]))
        else $error("channel 3 gain code not from bits 14:12");

    a_gain_ch2_code: assert property (
        wr_gain && avs_byteenable[1] |=> amp_gain_ch2 == $past(avs_writedata[10:8]))
        else $error("channel 2 gain code not from bits 10:8");

    a_gain_ch1_code: assert property (
        wr_gain && avs_byteenable[0] |=> amp_gain_ch1 == $past(avs_writedata[6:4]))
        else $error("channel 1 gain code not from bits 6:4");

    a_gain_ch0_code: assert property (
        wr_gain && avs_byteenable[0] |=> amp_gain_ch0 == $past(avs_writedata[2:0]))
        else $error("channel 0 gain code not from bits 2:0");

    a_gain_ch3: assert property (
        ##1 amp_gain_ch3_factor == GAIN_W'(GAIN_W'(1) << $past(amp_gain_ch3)))
        else $error("channel 3 gain factor wrong");

    a_gain_ch2: assert property (
        ##1 amp_gain_ch2_factor == GAIN_W'(GAIN_W'(1) << $past(amp_gain_ch2)))
        else $error("channel 2 gain factor wrong");

    a_gain_ch1: assert property (
        wr_gain && avs_byteenable[0] |=> ##1 amp_gain_ch1_factor ==
            GAIN_W'(GAIN_W'(1) << $past(avs_writedata[6:4], 2)))
        else $error("channel 1 gain factor not from its field");

    a_gain_ch0: assert property (
        ##1 amp_gain_ch0_factor == GAIN_W'(GAIN_W'(1) << $past(amp_gain_ch0)))
        else $error("channel 0 gain factor wrong");

    a_read_back: assert property (
        avs_read && !avs_waitrequest && avs_address == ADDR_W'(`ACG_ADDR_GAIN_LOW)
            |-> avs_readdata == {16'h0000, gain_low_reg})
        else $error("gain register read back wrong");

    a_read_clock: assert property (
        avs_read && !avs_waitrequest && avs_address == ADDR_W'(`ACG_ADDR_CLOCK)
            |-> avs_readdata == {26'h000_0000, clock_cfg_reg})
        else $error("clock configuration read back wrong");

    a_read_unmapped: assert property (
        accept && avs_read && avs_address != ADDR_W'(`ACG_ADDR_CLOCK)
            && avs_address != ADDR_W'(`ACG_ADDR_GAIN_LOW)
            |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped address did not read zero");

    c_write_clock: cover property (wr_clock);
    c_write_gain: cover property (wr_gain);
    c_read_gain: cover property (
        avs_read && !avs_waitrequest && avs_address == ADDR_W'(`ACG_ADDR_GAIN_LOW));
    c_unmapped: cover property (
        accept && avs_address != ADDR_W'(`ACG_ADDR_CLOCK)
            && avs_address != ADDR_W'(`ACG_ADDR_GAIN_LOW));
    c_top_ratio: cover property (oversampling_ratio_sel == 3'h7);

endmodule

// ===== rtl/acg_gain_decode.sv
`include "acg_regs.svh"

module acg_gain_decode
    import acg_pkg::*;
#(
    parameter int GAIN_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // gain code in, factor out
    input wire acg_gain_code_t gain_code,
    output logic [GAIN_W-1:0] gain_factor
);

    // factor is two to the power of the code
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gain_factor <= GAIN_W'(`ACG_GAIN_UNITY);
        end else begin
            gain_factor <= GAIN_W'(`ACG_GAIN_UNITY) << gain_code;
        end
    end

endmodule

// ===== rtl/acg_pkg.sv
package acg_pkg;

    typedef enum logic [1:0] {
        ACG_POWER_VERY_LOW,
        ACG_POWER_LOW,
        ACG_POWER_HIGH_RES
    } acg_power_t;

    typedef logic [2:0] acg_gain_code_t;

endpackage

// ===== rtl/acg_regs.svh
`ifndef ACG_REGS_SVH
`define ACG_REGS_SVH

// register byte addresses
`define ACG_ADDR_CLOCK 8'h00
`define ACG_ADDR_GAIN_LOW 8'h04

// clock configuration fields
`define ACG_POWER_LSB 0
`define ACG_POWER_MSB 1
`define ACG_RATIO_LSB 2
`define ACG_RATIO_MSB 4
`define ACG_CLK_RSVD_BIT 5
`define ACG_CLOCK_RESET 6'h0e

// gain register fields, channel n at bits 4n+2:4n, reserved at 4n+3
`define ACG_GAIN_STRIDE 4
`define ACG_GAIN_RESET 16'h0000

// oversampling ratio values
`define ACG_RATIO_BASE 15'h0080
`define ACG_RATIO_TOP_CODE 3'h7
`define ACG_RATIO_TOP 15'h3f80

// unity gain factor
`define ACG_GAIN_UNITY 8'h01

`endif

// ===== test/acg_config_regs_tb.sv
`include "acg_regs.svh"

module acg_config_regs_tb
    import acg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys;
    logic sys_rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest;
    logic [2:0] oversampling_ratio_sel;
    logic [14:0] oversampling_ratio;
    logic [1:0] power_mode_sel;
    acg_power_t power_mode;
    acg_gain_code_t gc [4];
    logic [7:0] gf [4];
    int fails;
    int checks;
    logic [31:0] rd;
    logic [15:0] g;
    logic [15:0] gain_now;
    logic [5:0] ck;

    acg_config_regs i_acg_config_regs (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .oversampling_ratio_sel(oversampling_ratio_sel),
        .oversampling_ratio(oversampling_ratio), .power_mode_sel(power_mode_sel),
        .power_mode(power_mode), .amp_gain_ch0(gc[0]), .amp_gain_ch1(gc[1]),
        .amp_gain_ch2(gc[2]), .amp_gain_ch3(gc[3]), .amp_gain_ch0_factor(gf[0]),
        .amp_gain_ch1_factor(gf[1]), .amp_gain_ch2_factor(gf[2]),
        .amp_gain_ch3_factor(gf[3])
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [31:0] exp);
        report(rd, exp);
    endtask

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        report(got, exp);
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] be);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
        chk_rd(exp);
    endtask

    function automatic logic [14:0] ratio_exp(input logic [2:0] c);
        return (c == 3'h7) ? 15'h3f80 : 15'(15'h0080 << c);
    endfunction

    function automatic acg_power_t power_exp(input logic [1:0] c);
        return (c == 2'h0) ? ACG_POWER_VERY_LOW
            : (c == 2'h1) ? ACG_POWER_LOW : ACG_POWER_HIGH_RES;
    endfunction

    task automatic check_outs(input logic [5:0] c, input logic [15:0] gv);
        @(negedge clk_sys);
        chk_out(32'(oversampling_ratio_sel), 32'(c[4:2]));
        chk_out(32'(oversampling_ratio), 32'(ratio_exp(c[4:2])));
        chk_out(32'(power_mode_sel), 32'(c[1:0]));
        chk_out(32'(power_mode), 32'(power_exp(c[1:0])));
        for (int i = 0; i < 4; i++) begin
            chk_out(32'(gc[i]), 32'(gv[4*i +: 3]));
            chk_out(32'(gf[i]), 32'(8'h01 << gv[4*i +: 3]));
        end
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        fails = 0;
        checks = 0;
        void'($urandom(5));
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk(`ACG_ADDR_CLOCK, 32'h0000_000e);
        rd_chk(`ACG_ADDR_GAIN_LOW, 32'h0000_0000);
        check_outs(6'h0e, 16'h0000);
        for (int c = 0; c < 32; c++) begin
            ck = 6'(c);
            bus(1'b1, `ACG_ADDR_CLOCK, 32'(ck), 4'h1);
            rd_chk(`ACG_ADDR_CLOCK, 32'(ck));
            check_outs(ck, 16'h0000);
        end
        // corners: all ones, then each channel alone, then random
        for (int k = 0; k < 24; k++) begin
            g = (k == 0) ? 16'h7777 : (k < 5) ? 16'(16'h0007 << (4 * (k - 1)))
                : 16'($urandom()) & 16'h7777;
            bus(1'b1, `ACG_ADDR_GAIN_LOW, 32'(g), 4'h3);
            gain_now = g;
            rd_chk(`ACG_ADDR_GAIN_LOW, 32'(g));
            check_outs(ck, g);
        end
        g = 16'($urandom()) & 16'h7777;
        bus(1'b1, `ACG_ADDR_GAIN_LOW, 32'(g), 4'h1);
        gain_now = {gain_now[15:8], g[7:0]};
        rd_chk(`ACG_ADDR_GAIN_LOW, 32'(gain_now));
        bus(1'b1, 8'h08, 32'h0000_7777, 4'hf);
        rd_chk(8'h08, 32'h0000_0000);
        rd_chk(`ACG_ADDR_GAIN_LOW, 32'(gain_now));
        check_outs(ck, gain_now);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk(`ACG_ADDR_GAIN_LOW, 32'h0000_0000);
        check_outs(6'h0e, 16'h0000);
        wrap_up();
    end
endmodule
